// File: hdl/mram_cmd_pkg.sv
// Constants, opcodes and state types of the serial memory command block.
// Assumes a 250 MHz system clock that oversamples the serial pins.
//
// How it works
// - Chip select low starts; opcode, three address bytes
// - Sample on rising, shift out on falling
// - One command per select; rise ends it
// - Status byte: disable bit7, protect 3:2, latch 1
// - Bits 6,5,4,0 store user values only
// - Every status bit starts at zero
// - Protect field picks none, quarter, half, all
// - Clear latch rejects array and status writes
// - Set latch allows writes outside protected region
// - Disable bit needs protect pin high to write
// - Status read allowed unless asleep, repeats until rise
// - Bit zero never set as busy
// - Set-latch opcode sets the latch
// - Clear-latch opcode clears the latch
// - Latch clears at every power-up
// - Status write ignored unless writable
// - Status survives power cycle except latch
// - Only low 17 address bits decoded
// - Read streams incrementing bytes until rise
// - Write stores incrementing bytes, no page limit
// - Address counter wraps to zero at top
// - Back-to-back writes need no busy wait
// - Sleep turns regulators off, low after delay
package mram_cmd_pkg;

    localparam int ADDR_BITS = 17;
    localparam int ADDR_BYTES = 3;

    localparam logic [7:0] OP_SET_LATCH = 8'h06;
    localparam logic [7:0] OP_CLEAR_LATCH = 8'h04;
    localparam logic [7:0] OP_STATUS_READ = 8'h05;
    localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
    localparam logic [7:0] OP_READ = 8'h03;
    localparam logic [7:0] OP_WRITE = 8'h02;
    localparam logic [7:0] OP_SLEEP = 8'hB9;
    localparam logic [7:0] OP_WAKE = 8'hAB;

    localparam int BIT_STATUS_WRITE_DISABLE = 7;
    localparam int BIT_BLOCK_PROTECT_HI = 3;
    localparam int BIT_BLOCK_PROTECT_LO = 2;
    localparam int BIT_WRITE_ENABLE_LATCH = 1;
    localparam logic [7:0] STATUS_RESET = 8'h00;

    localparam int CLK_MHZ = 250;
    localparam int SLEEP_ENTRY_NS = 3000;
    // Least time, rounded up to whole cycles
    localparam int SLEEP_ENTRY_CYCLES =
        (SLEEP_ENTRY_NS * CLK_MHZ + 999) / 1000;
    localparam int SLEEP_CNT_BITS = $clog2(SLEEP_ENTRY_CYCLES + 1);

    typedef enum logic [2:0] {
        ST_OPCODE, ST_ADDR, ST_READ, ST_WRITE,
        ST_STATUS_RD, ST_STATUS_WR, ST_IGNORE
    } cmd_state_t;

    // Protected region of the array for a given protect field
    function automatic logic addr_blocked(input logic [1:0] bp,
                                          input logic [ADDR_BITS-1:0] a);
        unique case (bp)
            2'h0: addr_blocked = 1'b0;
            2'h1: addr_blocked = &a[ADDR_BITS-1:ADDR_BITS-2];
            2'h2: addr_blocked = a[ADDR_BITS-1];
            2'h3: addr_blocked = 1'b1;
        endcase
    endfunction

endpackage

// File: hdl/stream_if.sv
// Valid/ready word stream between the command logic and its buffer.
// Assumes both ends run on the same clock.
interface stream_if #(parameter int WIDTH = 8) ();
    logic valid;
    logic ready;
    logic [WIDTH-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface

// File: hdl/word_buffer.sv
// Small FIFO with valid/ready on both sides.
// Assumes a power-of-two depth of at least two.
module word_buffer #(
    parameter int WIDTH = 25,
    parameter int DEPTH = 2
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Filling and draining sides
    stream_if.snk fill,
    stream_if.src drain
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    if (DEPTH < 2 || (1 << PW) != DEPTH) begin : g_depth_check
        $error("word_buffer: DEPTH must be a power of two, at least 2");
    end

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PW-1:0] rd;
        logic [PW-1:0] wr;
        logic [PW:0] count;
    } buf_state_t;

    buf_state_t r;
    buf_state_t next_r;
    logic push;
    logic pop;

    assign fill.ready = (r.count != (PW+1)'(DEPTH));
    assign drain.valid = (r.count != '0);
    assign drain.data = r.mem[r.rd];
    assign push = fill.valid && fill.ready;
    assign pop = drain.valid && drain.ready;

    always_comb begin
        next_r = r;
        if (push) begin
            next_r.mem[r.wr] = fill.data;
            next_r.wr = r.wr + PW'(1);
        end
        if (pop) begin
            next_r.rd = r.rd + PW'(1);
        end
        if (push && !pop) begin
            next_r.count = r.count + (PW+1)'(1);
        end else if (pop && !push) begin
            next_r.count = r.count - (PW+1)'(1);
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end
endmodule // word_buffer

// File: hdl/spi_mram_cmd_protect.sv
// Serial memory command decoder with status register and write guard.
// Assumes pins oversampled by clk; array answers reads within 12 cycles.
module spi_mram_cmd_protect
    import mram_cmd_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    input wire logic power_cycle,
    // Serial pins
    input wire logic cs_n,
    input wire logic sck,
    input wire logic si,
    input wire logic write_protect_n,
    output logic so,
    output logic so_oe,
    // Array write stream
    output logic mem_wr_valid,
    input wire logic mem_wr_ready,
    output logic [ADDR_BITS-1:0] mem_wr_addr,
    output logic [7:0] mem_wr_data,
    // Array read port
    output logic mem_rd_req,
    output logic [ADDR_BITS-1:0] mem_rd_addr,
    input wire logic mem_rd_valid,
    input wire logic [7:0] mem_rd_data,
    // Status and power
    output logic [7:0] protection_status,
    output logic clock_mode,
    output logic regulators_off,
    output logic standby_low_power
);
    localparam int WW = ADDR_BITS + 8;

    typedef struct packed {
        logic cs_s1;
        logic cs_s2;
        logic cs_s3;
        logic sck_s1;
        logic sck_s2;
        logic sck_s3;
        logic si_s1;
        logic si_s2;
        logic wp_s1;
        logic wp_s2;
        cmd_state_t st;
        logic [2:0] bit_cnt;
        logic [7:0] in_sr;
        logic [1:0] addr_cnt;
        logic [15:0] addr_sh;
        logic is_read;
        logic [ADDR_BITS-1:0] addr;
        logic [7:0] status;
        logic [7:0] rbuf;
        logic [7:0] out_sr;
        logic load_pend;
        logic so;
        logic so_oe;
        logic fetch_wait;
        logic rd_req;
        logic [ADDR_BITS-1:0] rd_addr;
        logic wr_pend;
        logic [WW-1:0] wr_word;
        logic mode;
        logic asleep;
        logic [SLEEP_CNT_BITS-1:0] sleep_cnt;
    } top_state_t;

    top_state_t r;
    top_state_t next_r;

    logic sck_rise;
    logic sck_fall;
    logic cs_low;
    logic cs_fall;
    logic [7:0] byte_in;
    logic [23:0] addr_full;
    logic status_writable;

    stream_if #(.WIDTH(WW)) buf_in ();
    stream_if #(.WIDTH(WW)) buf_out ();

    // Edges found on the second and third stages only
    assign sck_rise = r.sck_s2 && !r.sck_s3;
    assign sck_fall = !r.sck_s2 && r.sck_s3;
    assign cs_low = !r.cs_s2;
    assign cs_fall = !r.cs_s2 && r.cs_s3;
    assign byte_in = {r.in_sr[6:0], r.si_s2};
    assign addr_full = {r.addr_sh, byte_in};
    assign status_writable = r.status[BIT_WRITE_ENABLE_LATCH]
        && (!r.status[BIT_STATUS_WRITE_DISABLE] || r.wp_s2);

    assign buf_in.valid = r.wr_pend;
    assign buf_in.data = r.wr_word;
    assign mem_wr_valid = buf_out.valid;
    assign mem_wr_addr = buf_out.data[WW-1:8];
    assign mem_wr_data = buf_out.data[7:0];
    assign buf_out.ready = mem_wr_ready;

    assign so = r.so;
    assign so_oe = r.so_oe;
    assign mem_rd_req = r.rd_req;
    assign mem_rd_addr = r.rd_addr;
    assign protection_status = r.status;
    assign clock_mode = r.mode;
    assign regulators_off = r.asleep;
    assign standby_low_power = r.asleep
        && (r.sleep_cnt == SLEEP_CNT_BITS'(SLEEP_ENTRY_CYCLES));

    word_buffer #(.WIDTH(WW), .DEPTH(2)) u_buffer (
        .clk(clk),
        .rstn(rstn),
        .fill(buf_in.snk),
        .drain(buf_out.src)
    );

    always_comb begin
        next_r = r;
        next_r.rd_req = 1'b0;
        next_r.cs_s1 = cs_n;
        next_r.cs_s2 = r.cs_s1;
        next_r.cs_s3 = r.cs_s2;
        next_r.sck_s1 = sck;
        next_r.sck_s2 = r.sck_s1;
        next_r.sck_s3 = r.sck_s2;
        next_r.si_s1 = si;
        next_r.si_s2 = r.si_s1;
        next_r.wp_s1 = write_protect_n;
        next_r.wp_s2 = r.wp_s1;

        // Stalled word waits here until the buffer takes it
        if (r.wr_pend && buf_in.ready) begin
            next_r.wr_pend = 1'b0;
        end
        if (r.fetch_wait && mem_rd_valid) begin
            next_r.rbuf = mem_rd_data;
            next_r.fetch_wait = 1'b0;
        end
        if (r.asleep
            && r.sleep_cnt != SLEEP_CNT_BITS'(SLEEP_ENTRY_CYCLES)) begin
            next_r.sleep_cnt = r.sleep_cnt + SLEEP_CNT_BITS'(1);
        end

        if (!cs_low) begin
            // Select high ends any command at once
            next_r.st = ST_OPCODE;
            next_r.bit_cnt = 3'h0;
            next_r.so_oe = 1'b0;
            next_r.load_pend = 1'b0;
        end else begin
            if (cs_fall) begin
                next_r.mode = r.sck_s2;
            end
            if (sck_rise) begin
                // Input taken on rising edges only
                next_r.in_sr = byte_in;
                next_r.bit_cnt = r.bit_cnt + 3'h1;
                if (r.bit_cnt == 3'h7) begin
                    unique case (r.st)
                        ST_OPCODE: begin
                            next_r.st = ST_IGNORE;
                            if (r.asleep) begin
                                if (byte_in == OP_WAKE) begin
                                    next_r.asleep = 1'b0;
                                    next_r.sleep_cnt = '0;
                                end
                            end else begin
                                unique case (byte_in)
                                    OP_SET_LATCH: next_r.status[
                                        BIT_WRITE_ENABLE_LATCH] = 1'b1;
                                    OP_CLEAR_LATCH: next_r.status[
                                        BIT_WRITE_ENABLE_LATCH] = 1'b0;
                                    OP_STATUS_READ: begin
                                        next_r.st = ST_STATUS_RD;
                                        next_r.rbuf = r.status;
                                        next_r.load_pend = 1'b1;
                                    end
                                    OP_STATUS_WRITE:
                                        next_r.st = ST_STATUS_WR;
                                    OP_READ, OP_WRITE: begin
                                        next_r.st = ST_ADDR;
                                        next_r.addr_cnt = 2'h0;
                                        next_r.is_read = (byte_in == OP_READ);
                                    end
                                    OP_SLEEP: begin
                                        next_r.asleep = 1'b1;
                                        next_r.sleep_cnt = '0;
                                    end
                                    default: next_r.st = ST_IGNORE;
                                endcase
                            end
                        end
                        ST_ADDR: begin
                            next_r.addr_sh = addr_full[15:0];
                            next_r.addr_cnt = r.addr_cnt + 2'h1;
                            if (r.addr_cnt == 2'(ADDR_BYTES - 1)) begin
                                // Upper address bits dropped
                                next_r.addr = addr_full[ADDR_BITS-1:0];
                                if (r.is_read) begin
                                    next_r.st = ST_READ;
                                    next_r.rd_req = 1'b1;
                                    next_r.rd_addr =
                                        addr_full[ADDR_BITS-1:0];
                                    next_r.fetch_wait = 1'b1;
                                    next_r.load_pend = 1'b1;
                                end else begin
                                    next_r.st = ST_WRITE;
                                end
                            end
                        end
                        ST_READ: begin
                            next_r.load_pend = 1'b1;
                        end
                        ST_WRITE: begin
                            // Protected bytes vanish, no error shown
                            if (r.status[BIT_WRITE_ENABLE_LATCH]
                                && !addr_blocked(r.status[
                                    BIT_BLOCK_PROTECT_HI:
                                    BIT_BLOCK_PROTECT_LO],
                                    r.addr)) begin
                                next_r.wr_word = {r.addr, byte_in};
                                next_r.wr_pend = 1'b1;
                            end
                            // Natural 17-bit wrap to zero
                            next_r.addr = r.addr + ADDR_BITS'(1);
                        end
                        ST_STATUS_RD: begin
                            next_r.rbuf = r.status;
                            next_r.load_pend = 1'b1;
                        end
                        ST_STATUS_WR: begin
                            // One data byte only; latch kept by opcodes
                            next_r.st = ST_IGNORE;
                            if (status_writable) begin
                                next_r.status = {byte_in[7:2],
                                    r.status[BIT_WRITE_ENABLE_LATCH],
                                    byte_in[0]};
                            end
                        end
                        ST_IGNORE: begin
                            next_r.st = ST_IGNORE;
                        end
                    endcase
                end
            end else if (sck_fall) begin
                // Output changes on falling edges only
                if (r.load_pend) begin
                    next_r.load_pend = 1'b0;
                    next_r.so = r.rbuf[7];
                    next_r.out_sr = {r.rbuf[6:0], 1'b0};
                    next_r.so_oe = 1'b1;
                    if (r.st == ST_READ) begin
                        // Prefetch the next byte while this one shifts
                        next_r.addr = r.addr + ADDR_BITS'(1);
                        next_r.rd_addr = r.addr + ADDR_BITS'(1);
                        next_r.rd_req = 1'b1;
                        next_r.fetch_wait = 1'b1;
                    end
                end else if (r.so_oe) begin
                    next_r.so = r.out_sr[7];
                    next_r.out_sr = {r.out_sr[6:0], 1'b0};
                end
            end
        end

        if (power_cycle) begin
            // Of the status bits only the latch is volatile; sleep ends too
            next_r.status[BIT_WRITE_ENABLE_LATCH] = 1'b0;
            next_r.asleep = 1'b0;
            next_r.sleep_cnt = '0;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            r <= '0;
            r.cs_s1 <= 1'b1;
            r.cs_s2 <= 1'b1;
            r.cs_s3 <= 1'b1;
            r.st <= ST_OPCODE;
            r.status <= STATUS_RESET;
        end else begin
            r <= next_r;
        end
    end
endmodule // spi_mram_cmd_protect

// File: verif/spi_mram_cmd_protect_checker.sv
// Assertions on the command block's pins, status and array streams.
// Assumes the 250 MHz clock and a serial clock far slower than it.
module spi_mram_cmd_protect_checker
    import mram_cmd_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    input wire logic power_cycle,
    // Pins
    input wire logic cs_n,
    input wire logic so_oe,
    // Array side
    input wire logic mem_wr_valid,
    input wire logic mem_wr_ready,
    input wire logic [ADDR_BITS-1:0] mem_wr_addr,
    input wire logic [7:0] mem_wr_data,
    input wire logic mem_rd_req,
    // Status and power
    input wire logic [7:0] protection_status,
    input wire logic regulators_off,
    input wire logic standby_low_power
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    // Sleep span is counted; a repetition cannot reach that far
    int asleep;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) asleep <= 0;
        else asleep <= regulators_off ? asleep + 1 : 0;
    end
    property p_idle_quiet;
        cs_n [*5] |-> !so_oe;
    endproperty
    a_idle_quiet: assert property (p_idle_quiet)
        else $error("serial out driven while deselected");
    property p_wr_hold;
        mem_wr_valid && !mem_wr_ready |=> mem_wr_valid &&
            $stable(mem_wr_addr) && $stable(mem_wr_data);
    endproperty
    a_wr_hold: assert property (p_wr_hold)
        else $error("array word dropped while stalled");
    property p_latch_pc;
        power_cycle |=> !protection_status[BIT_WRITE_ENABLE_LATCH];
    endproperty
    a_latch_pc: assert property (p_latch_pc)
        else $error("latch survived power cycle");
    property p_keep_pc;
        power_cycle |=> (protection_status & 8'hFD) ==
            ($past(protection_status) & 8'hFD);
    endproperty
    a_keep_pc: assert property (p_keep_pc)
        else $error("status lost on power cycle");
    property p_status_frame;
        $changed(protection_status) && !$past(power_cycle) |->
            !$past(cs_n, 3);
    endproperty
    a_status_frame: assert property (p_status_frame)
        else $error("status changed outside a frame");
    // A busy flag would move together with array writes
    property p_busy_bit;
        $changed(protection_status[0]) |-> !$past(cs_n, 3) &&
            !mem_wr_valid && !$past(mem_wr_valid);
    endproperty
    a_busy_bit: assert property (p_busy_bit)
        else $error("bit zero set by the device");
    property p_rd_pulse;
        mem_rd_req |=> !mem_rd_req;
    endproperty
    a_rd_pulse: assert property (p_rd_pulse)
        else $error("fetch request longer than one cycle");
    property p_standby_late;
        standby_low_power |-> regulators_off &&
            asleep >= SLEEP_ENTRY_CYCLES - 2;
    endproperty
    a_standby_late: assert property (p_standby_late)
        else $error("standby reached too early");
    property p_standby_due;
        $rose(standby_low_power) |-> asleep <= SLEEP_ENTRY_CYCLES + 2;
    endproperty
    a_standby_due: assert property (p_standby_due)
        else $error("standby reached too late");
    c_disable_bit: cover property ($rose(protection_status[7]));
    c_stall: cover property (mem_wr_valid && !mem_wr_ready);
    c_standby: cover property ($rose(standby_low_power));
endmodule // spi_mram_cmd_protect_checker

bind spi_mram_cmd_protect spi_mram_cmd_protect_checker u_checker (
    .clk(clk), .rstn(rstn), .power_cycle(power_cycle), .cs_n(cs_n),
    .so_oe(so_oe), .mem_wr_valid(mem_wr_valid),
    .mem_wr_ready(mem_wr_ready), .mem_wr_addr(mem_wr_addr),
    .mem_wr_data(mem_wr_data), .mem_rd_req(mem_rd_req),
    .protection_status(protection_status),
    .regulators_off(regulators_off),
    .standby_low_power(standby_low_power)
);

// File: verif/mem_array_model.sv
// Array model behind the command block: stores words, answers fetches.
// Assumes fetches come far apart; slow mode stalls and delays answers.
module mem_array_model
    import mram_cmd_pkg::*;
(
    // Clock, reset and pacing
    input wire logic clk,
    input wire logic rstn,
    input wire logic slow,
    // Write stream
    input wire logic wr_valid,
    output logic wr_ready,
    input wire logic [ADDR_BITS-1:0] wr_addr,
    input wire logic [7:0] wr_data,
    // Fetch port
    input wire logic rd_req,
    input wire logic [ADDR_BITS-1:0] rd_addr,
    output logic rd_valid,
    output logic [7:0] rd_data
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] store[int];
    logic [2:0] pace;
    logic pend;
    int left;
    int a;
    assign wr_ready = !slow || pace == 3'h7;
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pace <= 3'h0;
            pend <= 1'b0;
            rd_valid <= 1'b0;
            rd_data <= 8'h00;
        end else begin
            pace <= pace + 3'h1;
            if (wr_valid && wr_ready) store[int'(wr_addr)] = wr_data;
            // Unanswered data toggles so a stale byte never matches
            rd_valid <= pend && left == 0;
            rd_data <= (pend && left == 0) ?
                (store.exists(a) ? store[a] : ~a[7:0]) : ~rd_data;
            if (pend && left == 0) pend <= 1'b0;
            else left <= left - 1;
            if (rd_req) begin
                pend <= 1'b1;
                a <= int'(rd_addr);
                left <= slow ? 9 : 0;
            end
        end
    end
endmodule // mem_array_model

// File: verif/spi_mram_cmd_protect_tb.sv
// Self-checking bench: serial frames from host tasks, array model behind.
// Assumes the package, the design and the array model compiled first.
`define CHK(what, exp, got) begin comparisons++; \
    if ((got) !== (exp)) begin bad_count++; \
        $display("unexpected %s expected %h seen %h", what, exp, got); \
    end end
module spi_mram_cmd_protect_tb
    import mram_cmd_pkg::*;
();
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic power_cycle = 1'b0;
    logic cs_n = 1'b1;
    logic sck = 1'b0;
    logic si = 1'b0;
    logic write_protect_n = 1'b1;
    logic slow = 1'b0;
    logic mode3 = 1'b0;
    logic zz = 1'b0;
    logic so, so_oe, wr_valid, wr_ready, rd_req, rd_valid, clock_mode;
    logic regulators_off, standby_low_power;
    logic [ADDR_BITS-1:0] wr_addr, rd_addr;
    logic [7:0] wr_data, rd_data, protection_status, exp_st;
    logic [7:0] rx[$];
    logic [7:0] shadow[int];
    int bad_count = 0;
    int comparisons = 0;
    always #2 clk = ~clk;
    spi_mram_cmd_protect DUT (.clk(clk), .rstn(rstn),
        .power_cycle(power_cycle), .cs_n(cs_n), .sck(sck), .si(si),
        .write_protect_n(write_protect_n), .so(so), .so_oe(so_oe),
        .mem_wr_valid(wr_valid), .mem_wr_ready(wr_ready),
        .mem_wr_addr(wr_addr), .mem_wr_data(wr_data), .mem_rd_req(rd_req),
        .mem_rd_addr(rd_addr), .mem_rd_valid(rd_valid),
        .mem_rd_data(rd_data), .protection_status(protection_status),
        .clock_mode(clock_mode), .regulators_off(regulators_off),
        .standby_low_power(standby_low_power));
    mem_array_model MEM (.clk(clk), .rstn(rstn), .slow(slow),
        .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_addr(wr_addr),
        .wr_data(wr_data), .rd_req(rd_req), .rd_addr(rd_addr),
        .rd_valid(rd_valid), .rd_data(rd_data));
    // Whole bytes only, so the device never sees a torn access
    task automatic frame(input logic [7:0] tx[$], input int nrx);
        logic [7:0] r;
        rx.delete();
        // Idle level settles first, so no false edge meets select
        sck = mode3;
        repeat (4) @(negedge clk);
        cs_n = 1'b0;
        repeat (20) @(negedge clk);
        for (int k = 0; k < tx.size() + nrx; k++) begin
            for (int i = 7; i >= 0; i--) begin
                sck = 1'b0;
                si = (k < tx.size()) ? tx[k][i] : 1'b0;
                repeat (20) @(negedge clk);
                sck = 1'b1;
                r[i] = so;
                repeat (20) @(negedge clk);
            end
            if (k >= tx.size()) rx.push_back(r);
        end
        sck = mode3;
        repeat (20) @(negedge clk);
        cs_n = 1'b1;
        repeat (20) @(negedge clk);
    endtask
    function automatic logic [7:0] peek(input int a);
        return shadow.exists(a) ? shadow[a] : ~a[7:0];
    endfunction
    function automatic logic guarded(input logic [1:0] bp, input int a);
        return bp == 2'h3 || (bp == 2'h2 && a >= 32'h10000) ||
            (bp == 2'h1 && a >= 32'h18000);
    endfunction
    task automatic cmd(input logic [7:0] op);
        frame({op}, 0);
        if (op == OP_WAKE) zz = 1'b0;
        else if (!zz && op == OP_SLEEP) zz = 1'b1;
        else if (!zz && op == OP_SET_LATCH) exp_st[1] = 1'b1;
        else if (!zz && op == OP_CLEAR_LATCH) exp_st[1] = 1'b0;
    endtask
    task automatic wstat(input logic [7:0] v);
        frame({OP_STATUS_WRITE, v}, 0);
        if (exp_st[1] && (!exp_st[7] || write_protect_n))
            exp_st = {v[7:2], exp_st[1], v[0]};
    endtask
    task automatic rstat();
        frame({OP_STATUS_READ}, 2);
        `CHK("status", exp_st, rx[0])
        `CHK("status repeat", exp_st, rx[1])
        `CHK("status port", exp_st, protection_status)
    endtask
    task automatic wmem(input logic [23:0] a, input logic [7:0] d[$]);
        int p;
        p = int'(a[16:0]);
        frame({OP_WRITE, a[23:16], a[15:8], a[7:0], d}, 0);
        foreach (d[i]) begin
            if (exp_st[1] && !guarded(exp_st[3:2], p)) shadow[p] = d[i];
            p = (p + 1) % 32'h20000;
        end
    endtask
    task automatic rmem(input logic [23:0] a, input int n);
        int p;
        p = int'(a[16:0]);
        frame({OP_READ, a[23:16], a[15:8], a[7:0]}, n);
        foreach (rx[i]) begin
            `CHK("array byte", peek(p), rx[i])
            p = (p + 1) % 32'h20000;
        end
    endtask
    task automatic summarize();
        $display("comparisons %0d bad_count %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    initial begin
        #360_000;
        bad_count++;
        summarize();
    end
    initial begin
        exp_st = STATUS_RESET;
        repeat (3) @(negedge clk);
        rstn = 1'b1;
        repeat (6) @(negedge clk);
        rstat();
        wmem(24'h000010, {8'hA5});
        rmem(24'h000010, 1);
        cmd(OP_SET_LATCH);
        rstat();
        wstat(8'h71);
        rstat();
        cmd(OP_CLEAR_LATCH);
        wstat(8'h00);
        rstat();
        slow = 1'b1;
        cmd(OP_SET_LATCH);
        for (int bp = 3; bp >= 0; bp--) begin
            wstat({4'h0, 2'(bp), 2'h0});
            rstat();
            wmem(24'h00FFFF, {8'(bp) + 8'h10, 8'(bp) + 8'h20});
            wmem(24'hFF7FFF, {8'(bp) + 8'h30, 8'(bp) + 8'h40});
            rmem(24'h00FFFF, 2);
            rmem(24'h017FFF, 2);
        end
        slow = 1'b0;
        wmem(24'h01FFFF, {8'h5A, 8'hC3});
        rmem(24'h01FFFF, 3);
        mode3 = 1'b1;
        rstat();
        `CHK("clock mode", 1'b1, clock_mode)
        mode3 = 1'b0;
        wstat(8'h80);
        `CHK("clock mode", 1'b0, clock_mode)
        write_protect_n = 1'b0;
        wstat(8'h8C);
        rstat();
        write_protect_n = 1'b1;
        wstat(8'h31);
        rstat();
        power_cycle = 1'b1;
        @(negedge clk);
        power_cycle = 1'b0;
        exp_st[1] = 1'b0;
        repeat (6) @(negedge clk);
        rstat();
        cmd(OP_SLEEP);
        `CHK("asleep", 1'b1, regulators_off)
        cmd(OP_SET_LATCH);
        repeat (SLEEP_ENTRY_CYCLES) @(negedge clk);
        `CHK("standby", 1'b1, standby_low_power)
        cmd(OP_WAKE);
        repeat (40) @(negedge clk);
        `CHK("awake", 1'b0, regulators_off)
        rstat();
        summarize();
    end
endmodule // spi_mram_cmd_protect_tb
